// ==== verilog/slc_link_regs.sv ====
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
// What this block does
// - enable bit 0 resets to 1; 0 disables link, 1 enables; 7:1 reserved.
// - while disabled the link is held in reset, serializers off, clocks gated.
// - while disabled the multiframe counter is held in reset, sysref ignored.
// - mode register bits 5:0 select output mode; 7:6 reserved; resets 0x00.
// - multiframe register holds frames per multiframe minus one; resets to 31.
// - in 64b/66b modes K is 256*E/F, the register ignored.
// - software sync bit resets 1; writing 0 raises a sync request.
// - software sync request is honoured whatever the sync source.
// - stuck-low sync pin holds request; source select 2 or 3 releases it.
// - option register: upper lanes, sync source, sample format, scrambler; resets 0x03.
// - sync source 0 single-ended pin, 1 timestamp pin with receiver, 2 none.
// - sample format 0 offset binary, 1 two's complement, default two's complement.
// - scrambler bit enables 8b/10b scrambling; 64b/66b always scrambles.
// - upper lane mapping uses lanes 4 to 4+L-1, only when L is four or less.
module slc_link_regs (
    input  wire logic                       MCLK_IN,
    input  wire logic                       RESETN_IN,
    input  wire logic                       PSEL_IN,
    input  wire logic                       PENABLE_IN,
    input  wire logic                       PWRITE_IN,
    input  wire logic [slc_pkg::ADDR_W-1:0] PADDR_IN,
    input  wire logic [31:0]                PWDATA_IN,
    output logic      [31:0]                PRDATA_OUT,
    output logic                            PREADY_OUT,
    output logic                            PSLVERR_OUT,
    input  wire logic                       SINGLE_ENDED_SYNC_PIN_IN,
    input  wire logic                       TIMESTAMP_DIFF_PIN_IN,
    input  wire logic                       TIMESTAMP_RECEIVER_ENABLE_IN,
    input  wire logic                       SYSREF_IN,
    input  wire logic [3:0]                 MODE_E_IN,
    input  wire logic [3:0]                 MODE_F_IN,
    input  wire logic [3:0]                 MODE_LANES_IN,
    output logic                            LINK_RESET_N_OUT,
    output logic                            SERIALIZER_POWER_OUT,
    output logic                            LINK_CLOCK_ENABLE_OUT,
    output logic                            MF_COUNTER_RESET_N_OUT,
    output logic                            MF_ALIGN_OUT,
    output logic                            SYNC_REQUEST_OUT,
    output logic      [5:0]                 LINK_OUTPUT_MODE_OUT,
    output logic      [9:0]                 FRAMES_PER_MULTIFRAME_OUT,
    output logic                            SAMPLE_FORMAT_OUT,
    output logic                            SCRAMBLER_ENABLE_OUT,
    output logic      [slc_pkg::LANES-1:0]  LANE_ENABLE_OUT,
    output logic                            CALIBRATION_ENABLE_OUT
);
    logic [31:0] prdata;
    logic        pslverr;
    logic [7:0]  en_r;
    logic [7:0]  mode_r;
    logic [7:0]  km1_r;
    logic [7:0]  sync_r;
    logic [7:0]  opt_r;
    logic [7:0]  cal_r;
    logic [7:0]  status;
    logic [9:0]  k_live;
    logic        is_64b;

    slc_pkg::slc_link_state_t st_q;
    slc_pkg::slc_link_state_t st_d;
    logic [5:0]  mode_q;
    logic [5:0]  mode_d;
    logic [9:0]  k_q;
    logic [9:0]  k_d;
    logic        sfmt_q;
    logic        sfmt_d;
    logic        scr_q;
    logic        scr_d;
    logic        upper_q;
    logic        upper_d;
    logic        b64_q;
    logic        b64_d;
    logic [3:0]  lanes_q;
    logic [3:0]  lanes_d;
    logic        rdy_q;
    logic        rdy_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic        err_q;
    logic        err_d;
    logic        sync_q;
    logic        sync_d;
    logic        align_q;
    logic        align_d;
    logic        sysref_q;
    logic        sysref_d;
    logic        run;
    logic        pin_req;
    logic [slc_pkg::LANES-1:0] lane_mask;

    slc_apb_slave u_bus (
        .clk_in      (MCLK_IN),
        .rst_n_in    (RESETN_IN),
        .psel_in     (PSEL_IN),
        .penable_in  (PENABLE_IN),
        .pwrite_in   (PWRITE_IN),
        .paddr_in    (PADDR_IN),
        .pwdata_in   (PWDATA_IN),
        .status_in   (status),
        .prdata_out  (prdata),
        .pslverr_out (pslverr),
        .enable_out  (en_r),
        .mode_out    (mode_r),
        .km1_out     (km1_r),
        .sync_out    (sync_r),
        .option_out  (opt_r),
        .cal_out     (cal_r)
    );

    // frame count follows the mode being written, ready for the snapshot
    slc_k_calc u_k (
        .mode_in    (mode_r[5:0]),
        .km1_in     (km1_r),
        .e_in       (MODE_E_IN),
        .f_in       (MODE_F_IN),
        .k_out      (k_live),
        .is_64b_out (is_64b)
    );

    // status: sync request, running, calibration
    assign status = {5'h00, sync_q, st_q == slc_pkg::LNK_RUN, cal_r[0]};
    assign run    = (st_q == slc_pkg::LNK_RUN);

    // low L lanes, moved up by four when upper mapping fits
    function automatic logic [slc_pkg::LANES-1:0] lanes_of(input logic [3:0] n,
                                                          input logic upper);
        logic [slc_pkg::LANES-1:0] m;
        m = slc_pkg::LANES'((9'h001 << n) - 9'h001);
        if (upper && n <= 4'(slc_pkg::UPPER_BASE))
            m = m << slc_pkg::UPPER_BASE;
        return m;
    endfunction

    assign lane_mask = lanes_of(lanes_q, upper_q);

    // link sequencing: configuration is snapshot on rising enable
    always_comb begin
        st_d    = st_q;
        mode_d  = mode_q;
        k_d     = k_q;
        sfmt_d  = sfmt_q;
        scr_d   = scr_q;
        upper_d = upper_q;
        b64_d   = b64_q;
        lanes_d = lanes_q;
        case (st_q)
            slc_pkg::LNK_OFF: begin
                if (en_r[0])
                    st_d = slc_pkg::LNK_LOAD;
            end
            slc_pkg::LNK_LOAD: begin
                // snapshot of the link configuration, except sync source and calibration, for the coming run
                mode_d  = mode_r[5:0];
                k_d     = k_live;
                sfmt_d  = opt_r[slc_pkg::OPT_SFMT];
                scr_d   = opt_r[slc_pkg::OPT_SCR] | is_64b;
                upper_d = opt_r[slc_pkg::OPT_UPPER];
                b64_d   = is_64b;
                lanes_d = MODE_LANES_IN;
                st_d    = en_r[0] ? slc_pkg::LNK_RUN : slc_pkg::LNK_OFF;
            end
            slc_pkg::LNK_RUN: begin
                // configuration stays frozen until the next enable
                if (!en_r[0])
                    st_d = slc_pkg::LNK_OFF;
            end
            default: st_d = slc_pkg::LNK_OFF;
        endcase
    end

    // sync request: software bit always counts, pin per source select
    always_comb begin
        case (opt_r[slc_pkg::OPT_SYNC_LO +: 2])
            slc_pkg::SYNC_SRC_SE: pin_req = ~SINGLE_ENDED_SYNC_PIN_IN;
            slc_pkg::SYNC_SRC_TS: pin_req = TIMESTAMP_RECEIVER_ENABLE_IN
                                            & ~TIMESTAMP_DIFF_PIN_IN;
            default:              pin_req = 1'b0;
        endcase
        sync_d   = run & (~sync_r[0] | pin_req);
        sysref_d = SYSREF_IN;
        // align only on a sysref rising edge while running
        align_d  = run & SYSREF_IN & ~sysref_q;
    end

    // setup phase of an apb transfer: request seen, access not yet
    function automatic logic is_setup(input logic sel,
                                      input logic en);
        return sel & ~en;
    endfunction

    // bus answer registered: no wait state; data and error decided in setup
    always_comb begin
        rdy_d  = is_setup(PSEL_IN, PENABLE_IN);
        rdat_d = rdat_q;
        err_d  = 1'b0;
        if (is_setup(PSEL_IN, PENABLE_IN)) begin
            rdat_d = PWRITE_IN ? 32'h00000000 : prdata;
            err_d  = pslverr;
        end
        if (PSEL_IN & PENABLE_IN & rdy_q) begin
            rdat_d = 32'h00000000;
        end
    end

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            st_q     <= slc_pkg::LNK_OFF;
            mode_q   <= 6'h00;
            k_q      <= 10'h000;
            sfmt_q   <= 1'b0;
            scr_q    <= 1'b0;
            upper_q  <= 1'b0;
            b64_q    <= 1'b0;
            lanes_q  <= 4'h0;
            rdy_q    <= 1'b0;
            rdat_q   <= 32'h00000000;
            err_q    <= 1'b0;
            sync_q   <= 1'b0;
            align_q  <= 1'b0;
            sysref_q <= 1'b0;
        end else begin
            st_q     <= st_d;
            mode_q   <= mode_d;
            k_q      <= k_d;
            sfmt_q   <= sfmt_d;
            scr_q    <= scr_d;
            upper_q  <= upper_d;
            b64_q    <= b64_d;
            lanes_q  <= lanes_d;
            rdy_q    <= rdy_d;
            rdat_q   <= rdat_d;
            err_q    <= err_d;
            sync_q   <= sync_d;
            align_q  <= align_d;
            sysref_q <= sysref_d;
        end
    end

    // output stage
    // top outputs all leave flip-flops; zero while in reset
    logic       lrst_q;
    logic       pwr_q;
    logic       clk_q;
    logic       mfr_q;
    logic       cal_q;
    logic [5:0] omode_q;
    logic [9:0] ok_q;
    logic       osfmt_q;
    logic       oscr_q;
    logic [slc_pkg::LANES-1:0] olane_q;

    always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            lrst_q  <= 1'b0;
            pwr_q   <= 1'b0;
            clk_q   <= 1'b0;
            mfr_q   <= 1'b0;
            cal_q   <= 1'b0;
            omode_q <= 6'h00;
            ok_q    <= 10'h000;
            osfmt_q <= 1'b0;
            oscr_q  <= 1'b0;
            olane_q <= '0;
        end else begin
            lrst_q  <= run;
            pwr_q   <= run;
            clk_q   <= run;
            mfr_q   <= run;
            cal_q   <= cal_r[0];
            omode_q <= mode_q;
            ok_q    <= k_q;
            osfmt_q <= sfmt_q;
            oscr_q  <= scr_q | b64_q;
            olane_q <= run ? lane_mask : '0;
        end
    end

    assign PRDATA_OUT                = rdat_q;
    assign PREADY_OUT                = rdy_q;
    assign PSLVERR_OUT               = err_q;
    assign LINK_RESET_N_OUT          = lrst_q;
    assign SERIALIZER_POWER_OUT      = pwr_q;
    assign LINK_CLOCK_ENABLE_OUT     = clk_q;
    assign MF_COUNTER_RESET_N_OUT    = mfr_q;
    assign MF_ALIGN_OUT              = align_q;
    assign SYNC_REQUEST_OUT          = sync_q;
    assign LINK_OUTPUT_MODE_OUT      = omode_q;
    assign FRAMES_PER_MULTIFRAME_OUT = ok_q;
    assign SAMPLE_FORMAT_OUT         = osfmt_q;
    assign SCRAMBLER_ENABLE_OUT      = oscr_q;
    assign LANE_ENABLE_OUT           = olane_q;
    assign CALIBRATION_ENABLE_OUT    = cal_q;
endmodule

// ==== inc/slc_pkg.sv ====
package slc_pkg;
    // register indices; the byte address on the bus is index * 4
    localparam logic [11:0] IDX_ENABLE    = 12'h200;
    localparam logic [11:0] IDX_MODE      = 12'h201;
    localparam logic [11:0] IDX_KM1       = 12'h202;
    localparam logic [11:0] IDX_SYNC      = 12'h203;
    localparam logic [11:0] IDX_OPTION    = 12'h204;
    localparam logic [11:0] IDX_CAL       = 12'h208;
    localparam logic [11:0] IDX_STATUS    = 12'h209;
    localparam int          ADDR_SHIFT    = 2;
    localparam int          ADDR_W        = 14;

    // reset values
    localparam logic [7:0] RST_ENABLE = 8'h01;
    localparam logic [7:0] RST_MODE   = 8'h00;
    localparam logic [7:0] RST_KM1    = 8'h1f;
    localparam logic [7:0] RST_SYNC   = 8'h01;
    localparam logic [7:0] RST_OPTION = 8'h03;
    localparam logic [7:0] RST_CAL    = 8'h00;

    // field masks (reserved bits stay zero)
    localparam logic [7:0] MSK_ENABLE = 8'h01;
    localparam logic [7:0] MSK_MODE   = 8'h3f;
    localparam logic [7:0] MSK_KM1    = 8'hff;
    localparam logic [7:0] MSK_SYNC   = 8'h01;
    localparam logic [7:0] MSK_OPTION = 8'h1f;
    localparam logic [7:0] MSK_CAL    = 8'h01;

    // option field positions
    localparam int OPT_SCR      = 0;
    localparam int OPT_SFMT     = 1;
    localparam int OPT_SYNC_LO  = 2;
    localparam int OPT_UPPER    = 4;

    localparam logic [1:0] SYNC_SRC_SE   = 2'h0;
    localparam logic [1:0] SYNC_SRC_TS   = 2'h1;
    localparam logic [1:0] SYNC_SRC_NONE = 2'h2;

    localparam logic [5:0] MODE_64B66B_FIRST = 6'h1e;
    localparam logic [9:0] K_64B66B_SCALE    = 10'h100;
    localparam int         LANES             = 8;
    localparam int         UPPER_BASE        = 4;

    typedef enum logic [2:0] {
        LNK_OFF   = 3'b001,
        LNK_LOAD  = 3'b010,
        LNK_RUN   = 3'b100
    } slc_link_state_t;
endpackage

// ==== verilog/slc_apb_slave.sv ====
`timescale 1ns/1ps
module slc_apb_slave (
    input  wire logic                       clk_in,
    input  wire logic                       rst_n_in,
    input  wire logic                       psel_in,
    input  wire logic                       penable_in,
    input  wire logic                       pwrite_in,
    input  wire logic [slc_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]                pwdata_in,
    input  wire logic [7:0]                 status_in,
    output logic      [31:0]                prdata_out,
    output logic                            pslverr_out,
    output logic      [7:0]                 enable_out,
    output logic      [7:0]                 mode_out,
    output logic      [7:0]                 km1_out,
    output logic      [7:0]                 sync_out,
    output logic      [7:0]                 option_out,
    output logic      [7:0]                 cal_out
);
    logic [7:0] en_q, en_d, md_q, md_d, km_q, km_d, sy_q, sy_d, op_q, op_d, cl_q, cl_d;
    logic [11:0] idx;
    logic        hit, wr;
    logic [7:0]  rd;

    assign idx = paddr_in[slc_pkg::ADDR_W-1:slc_pkg::ADDR_SHIFT];
    assign wr  = psel_in & penable_in & pwrite_in & hit;

    always_comb begin
        hit = 1'b1;
        rd  = 8'h00;
        case (idx)
            slc_pkg::IDX_ENABLE: rd = en_q;
            slc_pkg::IDX_MODE:   rd = md_q;
            slc_pkg::IDX_KM1:    rd = km_q;
            slc_pkg::IDX_SYNC:   rd = sy_q;
            slc_pkg::IDX_OPTION: rd = op_q;
            slc_pkg::IDX_CAL:    rd = cl_q;
            slc_pkg::IDX_STATUS: rd = status_in;
            default:             hit = 1'b0;
        endcase
    end

    always_comb begin
        en_d = en_q;
        md_d = md_q;
        km_d = km_q;
        sy_d = sy_q;
        op_d = op_q;
        cl_d = cl_q;
        if (wr) begin
            case (idx)
                slc_pkg::IDX_ENABLE: en_d = pwdata_in[7:0] & slc_pkg::MSK_ENABLE;
                slc_pkg::IDX_MODE:   md_d = pwdata_in[7:0] & slc_pkg::MSK_MODE;
                slc_pkg::IDX_KM1:    km_d = pwdata_in[7:0] & slc_pkg::MSK_KM1;
                slc_pkg::IDX_SYNC:   sy_d = pwdata_in[7:0] & slc_pkg::MSK_SYNC;
                slc_pkg::IDX_OPTION: op_d = pwdata_in[7:0] & slc_pkg::MSK_OPTION;
                slc_pkg::IDX_CAL:    cl_d = pwdata_in[7:0] & slc_pkg::MSK_CAL;
                default:             ;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en_q <= slc_pkg::RST_ENABLE;
            md_q <= slc_pkg::RST_MODE;
            km_q <= slc_pkg::RST_KM1;
            sy_q <= slc_pkg::RST_SYNC;
            op_q <= slc_pkg::RST_OPTION;
            cl_q <= slc_pkg::RST_CAL;
        end else begin
            en_q <= en_d;
            md_q <= md_d;
            km_q <= km_d;
            sy_q <= sy_d;
            op_q <= op_d;
            cl_q <= cl_d;
        end
    end

    // unmapped index flagged in the setup phase; reads zero
    assign prdata_out  = {24'h000000, rd};
    assign pslverr_out = psel_in & ~penable_in & ~hit;
    assign enable_out  = en_q;
    assign mode_out    = md_q;
    assign km1_out     = km_q;
    assign sync_out    = sy_q;
    assign option_out  = op_q;
    assign cal_out     = cl_q;
endmodule

// ==== verilog/slc_k_calc.sv ====
`timescale 1ns/1ps
module slc_k_calc (
    input  wire logic [5:0] mode_in,
    input  wire logic [7:0] km1_in,
    input  wire logic [3:0] e_in,
    input  wire logic [3:0] f_in,
    output logic      [9:0] k_out,
    output logic            is_64b_out
);
    logic [13:0] prod;
    logic [9:0]  quot;

    assign is_64b_out = (mode_in >= slc_pkg::MODE_64B66B_FIRST);
    assign prod = 14'(slc_pkg::K_64B66B_SCALE) * 14'(e_in);
    assign quot = (f_in == 4'h0) ? slc_pkg::K_64B66B_SCALE : 10'(prod / 14'(f_in));
    // 64b/66b ignores the programmed value, K = 256*E/F
    assign k_out = is_64b_out ? quot : 10'(km1_in) + 10'h001;
endmodule

// ==== sim/slc_link_regs_monitor.sv ====
`timescale 1ns/1ps
module slc_link_regs_monitor (
    input wire logic                       MCLK_IN,
    input wire logic                       RESETN_IN,
    input wire logic                       PSEL_IN,
    input wire logic                       PENABLE_IN,
    input wire logic                       PWRITE_IN,
    input wire logic [slc_pkg::ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0]                PWDATA_IN,
    input wire logic [31:0]                PRDATA_OUT,
    input wire logic                       PREADY_OUT,
    input wire logic                       PSLVERR_OUT,
    input wire logic                       LINK_RESET_N_OUT,
    input wire logic                       SERIALIZER_POWER_OUT,
    input wire logic                       LINK_CLOCK_ENABLE_OUT,
    input wire logic                       MF_COUNTER_RESET_N_OUT,
    input wire logic                       MF_ALIGN_OUT,
    input wire logic                       SYNC_REQUEST_OUT,
    input wire logic [5:0]                 LINK_OUTPUT_MODE_OUT,
    input wire logic [9:0]                 FRAMES_PER_MULTIFRAME_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!RESETN_IN);
    logic [11:0] idx;
    logic        map;
    logic        acc;
    assign idx = PADDR_IN[13:2];
    assign map = (idx >= 12'h200 && idx <= 12'h204) || idx == 12'h208 || idx == 12'h209;
    assign acc = PSEL_IN && PENABLE_IN && PREADY_OUT;
    a_ready_after_setup: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (acc && !map |-> PSLVERR_OUT)
        else $error("unmapped access without error");
    a_err_mapped: assert property (acc && map |-> !PSLVERR_OUT)
        else $error("error on mapped register");
    a_read_upper_zero: assert property (acc && !PWRITE_IN |-> PRDATA_OUT[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_disable_stops_link: assert property (acc && PWRITE_IN && idx == 12'h200 && !PWDATA_IN[0]
        |-> ##[1:3] !LINK_RESET_N_OUT)
        else $error("link not stopped after disable");
    a_enable_starts_link: assert property (acc && PWRITE_IN && idx == 12'h200 && PWDATA_IN[0]
        |-> ##[1:4] LINK_RESET_N_OUT)
        else $error("link not started after enable");
    a_off_all_together: assert property (LINK_RESET_N_OUT == SERIALIZER_POWER_OUT
        && LINK_RESET_N_OUT == LINK_CLOCK_ENABLE_OUT
        && LINK_RESET_N_OUT == MF_COUNTER_RESET_N_OUT)
        else $error("link controls disagree");
    a_no_align_off: assert property (!MF_COUNTER_RESET_N_OUT [*2] |-> !MF_ALIGN_OUT)
        else $error("align while counter held");
    a_align_pulse: assert property (MF_ALIGN_OUT |=> !MF_ALIGN_OUT)
        else $error("align longer than one cycle");
    a_cfg_static_run: assert property (LINK_RESET_N_OUT && $past(LINK_RESET_N_OUT)
        |-> $stable(LINK_OUTPUT_MODE_OUT) && $stable(FRAMES_PER_MULTIFRAME_OUT))
        else $error("config changed while running");
    a_no_sync_off: assert property (!LINK_RESET_N_OUT [*2] |-> !SYNC_REQUEST_OUT)
        else $error("sync request while off");
    c_unmapped: cover property (acc && !map);
    c_align: cover property (MF_ALIGN_OUT);
    c_sync: cover property (SYNC_REQUEST_OUT);
endmodule
bind slc_link_regs slc_link_regs_monitor u_mon (.MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .LINK_RESET_N_OUT(LINK_RESET_N_OUT),
    .SERIALIZER_POWER_OUT(SERIALIZER_POWER_OUT), .LINK_CLOCK_ENABLE_OUT(LINK_CLOCK_ENABLE_OUT),
    .MF_COUNTER_RESET_N_OUT(MF_COUNTER_RESET_N_OUT), .MF_ALIGN_OUT(MF_ALIGN_OUT),
    .SYNC_REQUEST_OUT(SYNC_REQUEST_OUT), .LINK_OUTPUT_MODE_OUT(LINK_OUTPUT_MODE_OUT),
    .FRAMES_PER_MULTIFRAME_OUT(FRAMES_PER_MULTIFRAME_OUT));

// ==== sim/slc_link_regs_tb_top.sv ====
`timescale 1ns/1ps
module slc_link_regs_tb_top;
    typedef struct {logic rd; logic [31:0] d; logic err;} slc_exp_t;
    logic        clk, rst_n, psel, pen, pwr, se, ts, ts_en, sysref;
    logic        prdy, perr, lrst_n, spwr, lclk, mfrst_n, mfal, sreq, fmt, scram, cal, seen;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  e, f, nl;
    logic [5:0]  omode;
    logic [9:0]  kout;
    logic [7:0]  lanes, m, kmo;
    int          failures = 0;
    int          tests_run = 0;
    slc_exp_t    q[$];
    slc_link_regs u_dut (.MCLK_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .SINGLE_ENDED_SYNC_PIN_IN(se),
        .TIMESTAMP_DIFF_PIN_IN(ts), .TIMESTAMP_RECEIVER_ENABLE_IN(ts_en), .SYSREF_IN(sysref),
        .MODE_E_IN(e), .MODE_F_IN(f), .MODE_LANES_IN(nl), .LINK_RESET_N_OUT(lrst_n),
        .SERIALIZER_POWER_OUT(spwr), .LINK_CLOCK_ENABLE_OUT(lclk),
        .MF_COUNTER_RESET_N_OUT(mfrst_n), .MF_ALIGN_OUT(mfal), .SYNC_REQUEST_OUT(sreq),
        .LINK_OUTPUT_MODE_OUT(omode), .FRAMES_PER_MULTIFRAME_OUT(kout),
        .SAMPLE_FORMAT_OUT(fmt), .SCRAMBLER_ENABLE_OUT(scram), .LANE_ENABLE_OUT(lanes),
        .CALIBRATION_ENABLE_OUT(cal));
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(string n, logic [31:0] x, logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask
    // one apb transfer; the watcher below judges the answer
    task automatic apb(logic w, logic [11:0] idx, logic [7:0] d, logic [7:0] x, logic err);
        int n;
        q.push_back('{!w, {24'h0, x}, err});
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk) pen <= 1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            give_verdict();
        end
        @(posedge clk);
        psel <= 0;
        pen <= 0;
    endtask
    task automatic settle;
        repeat (4) @(negedge clk);
    endtask
    always @(posedge clk) begin
        if (psel && pen && prdy === 1'b1 && q.size() > 0) begin
            if (q[0].rd) check("prdata", q[0].d, prdata);
            check("pslverr", q[0].err, perr);
            q.delete(0);
        end
    end
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        {psel, pen, pwr, paddr, pwdata, se, ts, ts_en, sysref, seen} = '0;
        e = 4'h2;
        f = 4'h8;
        nl = 4'h4;
        rst_n = 0;
        m = $urandom(32'he646);
        repeat (3) @(posedge clk);
        rst_n <= 1;
        apb(0, 12'h200, 0, 8'h01, 0);
        apb(0, 12'h201, 0, 8'h00, 0);
        apb(0, 12'h202, 0, 8'h1f, 0);
        apb(0, 12'h203, 0, 8'h01, 0);
        apb(0, 12'h204, 0, 8'h03, 0);
        apb(0, 12'h300, 0, 8'h00, 1);
        check("link_on", 4'hf, {lrst_n, spwr, lclk, mfrst_n});
        check("k_reset", 10'd32, kout);
        check("fmt_scram", 2'b11, {fmt, scram});
        apb(1, 12'h200, 8'h00, 0, 0);
        settle();
        check("link_off", 4'h0, {lrst_n, spwr, lclk, mfrst_n});
        @(posedge clk) sysref <= 1;
        repeat (4) @(negedge clk) seen = seen | mfal;
        check("align_off", 1'b0, seen);
        m = 8'($urandom_range(0, 29));
        kmo = 8'($urandom);
        apb(1, 12'h201, m, 0, 0);
        apb(0, 12'h201, 0, m, 0);
        apb(1, 12'h202, kmo, 0, 0);
        apb(0, 12'h202, 0, kmo, 0);
        apb(1, 12'h204, 8'h10, 0, 0);
        apb(0, 12'h204, 0, 8'h10, 0);
        check("mode_held", 6'h00, omode);
        apb(1, 12'h208, 8'h01, 0, 0);
        apb(1, 12'h200, 8'h01, 0, 0);
        settle();
        check("link_on2", 4'hf, {lrst_n, spwr, lclk, mfrst_n, 27'h0} >> 27);
        check("mode", m[5:0], omode);
        check("k", kmo + 10'd1, kout);
        check("fmt_scram2", 2'b00, {fmt, scram});
        check("upper_lanes", 8'hf0, lanes);
        check("cal", 1'b1, cal);
        apb(0, 12'h209, 0, 8'h07, 0);
        @(posedge clk) sysref <= 0;
        @(posedge clk) sysref <= 1;
        repeat (4) @(negedge clk) seen = seen | mfal;
        check("align_on", 1'b1, seen);
        apb(1, 12'h200, 8'h00, 0, 0);
        apb(1, 12'h208, 8'h00, 0, 0);
        apb(1, 12'h201, 8'h1e, 0, 0);
        apb(1, 12'h208, 8'h01, 0, 0);
        nl <= 4'h6;
        apb(1, 12'h200, 8'h01, 0, 0);
        settle();
        check("k_64b", 10'd64, kout);
        check("scram_64b", 1'b1, scram);
        check("lanes_l6", 8'h3f, lanes);
        for (int s = 0; s < 3; s++) begin
            apb(1, 12'h200, 8'h00, 0, 0);
            apb(1, 12'h204, {4'h0, 2'(s), 2'b11}, 0, 0);
            apb(1, 12'h200, 8'h01, 0, 0);
            se <= 0;
            ts <= 1;
            ts_en <= 1;
            settle();
            check("sync_se_low", s == 0, sreq);
            @(posedge clk) {se, ts} <= 2'b10;
            settle();
            check("sync_ts_low", s == 1, sreq);
            @(posedge clk) ts <= 1;
            apb(1, 12'h203, 8'h00, 0, 0);
            settle();
            check("sync_sw", 1'b1, sreq);
            apb(1, 12'h203, 8'h01, 0, 0);
        end
        apb(1, 12'h200, 8'h00, 0, 0);
        apb(1, 12'h208, 8'h00, 0, 0);
        apb(0, 12'h208, 0, 8'h00, 0);
        settle();
        give_verdict();
    end
endmodule
